// [cif_gpio_params.svh]
// constants for the cpu interface gpio and queue status block
// assumes a 12-bit byte address and 32-bit register words
`ifndef CIF_GPIO_PARAMS_SVH
`define CIF_GPIO_PARAMS_SVH

`define CIF_ADDR_W      12
`define CIF_OFS_CTRL    12'h000
`define CIF_OFS_STATUS  12'h004
`define CIF_OFS_PIN_LO  12'h008
`define CIF_OFS_PIN_HI  12'h00C

`define CIF_TSEL_LSB    4
`define CIF_TDATA_LSB   6
`define CIF_CMD_LSB     0
`define CIF_SRC_LSB     8
`define CIF_BUSY_BIT    16
`define CIF_HI_GRP_LSB  8

`define CIF_GRP_W       4
`define CIF_GRP_IN      0
`define CIF_GRP_OE      1
`define CIF_GRP_SRC     2
`define CIF_GRP_DAT     3

`define CIF_TSEL_USB    2'h0
`define CIF_TSEL_MIU    2'h1
`define CIF_TSEL_CIF    2'h2
`define CIF_RST_TSEL    2'h0
`define CIF_RST_TDATA   2'h0
`define CIF_RST_PIN_LO  32'h00111100
`define CIF_RST_PIN_HI  32'h00000100

`define CIF_PIN_N       9
`define CIF_PIN_LO_N    8
`define CIF_PIN_HI_IDX  8
`define CIF_PIN_LARGE   5
`define CIF_PIN_PD_EN   3
`define CIF_PIN_PDWN    4
`define CIF_STRAP_N     3
`define CIF_FREE_W      5

`endif

// [cif_gpio_pkg.sv]
// types shared by the cpu interface gpio block
// assumes cif_gpio_params.svh sets the widths
`include "cif_gpio_params.svh"
`default_nettype none
package cif_gpio_pkg;
    typedef logic [`CIF_GRP_W-1:0]  pin_group_t;
    typedef logic [31:0]            word_t;
    typedef logic [1:0]             test_sel_t;
endpackage
`default_nettype wire

// [cif_gpio.sv]
// cpu interface gpio control words and queue / engine status word
// assumes one clock, pins synchronised here, status inputs on core_clk
`include "cif_gpio_params.svh"
`default_nettype none

// Contract
// (R1) test select 00 usb, 01 memory controller, 10 cpu interface, 11 reserved
// (R2) command queue free count, 5 bits, 0 full, 16 empty
// (R3) source queue free count, 5 bits at 12:8, 0 full, 16 empty
// (R4) engine busy bit 16 follows the engine's busy signal
// (R5) four-bit group per pin; source select picks data bit or test signal
// (R6) output enable drives data bit; input enable makes reads return pin level
// (R7) pins 0 to 2 caught at reset release as mode straps
// (R8) pin 3 caught at reset release enables the power-down input
// (R9) power-down enabled: pin 4 is power-down input, no output mode
// (R10) after reset outputs off; input on for pins 2 to 5 and pin 20
// (R11) bus clock pin is gpio 6, bits 27:24, all off after reset
// (R12) bus strobe pin is gpio 7, bits 31:28, data in bit 31
// (R13) software writes zeros to reserved bits 5:0 of the high word
// (R14) pin 5 and pin 20 exist only on the large variant
// (R15) reserved bits read zero, writes to them ignored
module cif_gpio
    import cif_gpio_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int QUEUE_DEPTH   = 16
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic [`CIF_ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output var  logic [31:0]               reg_rdata,
    input  wire logic [`CIF_FREE_W-1:0]    command_queue_free_count,
    input  wire logic [`CIF_FREE_W-1:0]    source_queue_free_count,
    input  wire logic                      engine_busy,
    input  wire logic [`CIF_PIN_N-1:0]     usb_test_data,
    input  wire logic [`CIF_PIN_N-1:0]     miu_test_data,
    input  wire logic [`CIF_PIN_N-1:0]     pin_in,
    output var  logic [`CIF_PIN_N-1:0]     pin_out,
    output var  logic [`CIF_PIN_N-1:0]     pin_oe,
    output var  logic [`CIF_STRAP_N-1:0]   mode_strap,
    output var  logic                      power_down_enable,
    output var  logic                      power_down_input_n
);

    ////////////////////////////////////////////////////////////////////////////
    // parameter checks

    // a depth the fixed field cannot count would read back wrapped
    if ($clog2(QUEUE_DEPTH) + 1 != `CIF_FREE_W) begin : g_depth_chk
        $error("queue depth does not fit the free-count field");
    end

    // the high word carries exactly one group beyond the low word's eight
    if (`CIF_PIN_N != `CIF_PIN_LO_N + 1) begin : g_pin_chk
        $error("pin count does not match the two control words");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic pin_exists(input int idx);
        pin_exists = LARGE_VARIANT ||
                     ((idx != `CIF_PIN_LARGE) && (idx != `CIF_PIN_HI_IDX));
    endfunction

    // reset words are copied into variables first; a literal cannot be part-selected
    function automatic pin_group_t reset_group(input int idx);
        word_t      lo;
        word_t      hi;
        pin_group_t g;
        lo = `CIF_RST_PIN_LO;
        hi = `CIF_RST_PIN_HI;
        if (idx == `CIF_PIN_HI_IDX) begin
            g = hi[`CIF_HI_GRP_LSB +: `CIF_GRP_W];
        end else begin
            g = lo[idx*`CIF_GRP_W +: `CIF_GRP_W];
        end
        reset_group = pin_exists(idx) ? g : '0;
    endfunction

    // data bit reads the pin when input mode is on, else the stored value
    function automatic pin_group_t group_view(input pin_group_t g, input logic lvl);
        pin_group_t v;
        v = g;
        if (g[`CIF_GRP_IN]) begin
            v[`CIF_GRP_DAT] = lvl; // see (R6)
        end
        group_view = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; not reset so straps are settled by reset release

    logic [`CIF_PIN_N-1:0] pin_s1_r;
    logic [`CIF_PIN_N-1:0] pin_s2_r;

    always_ff @(posedge core_clk) begin
        pin_s1_r <= pin_in;
        pin_s2_r <= pin_s1_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture at the first edge after reset release

    logic                    in_reset_r;
    logic [`CIF_STRAP_N-1:0] strap_r;
    logic [`CIF_STRAP_N-1:0] strap_nxt;
    logic                    pd_en_r;
    logic                    pd_en_nxt;
    logic                    pd_in_n_r;
    logic                    pd_in_n_nxt;

    always_comb begin
        strap_nxt   = strap_r;
        pd_en_nxt   = pd_en_r;
        if (in_reset_r) begin
            strap_nxt = pin_s2_r[`CIF_STRAP_N-1:0]; // see (R7)
            pd_en_nxt = pin_s2_r[`CIF_PIN_PD_EN];   // see (R8)
        end
        // pin 4 is the active-low power-down input when enabled
        pd_in_n_nxt = pd_en_r ? pin_s2_r[`CIF_PIN_PDWN] : 1'b1; // see (R9)
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            in_reset_r <= 1'b1;
            strap_r    <= '0;
            pd_en_r    <= 1'b0;
            pd_in_n_r  <= 1'b1;
        end else begin
            in_reset_r <= 1'b0;
            strap_r    <= strap_nxt;
            pd_en_r    <= pd_en_nxt;
            pd_in_n_r  <= pd_in_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control word: test source select and cpu test data

    test_sel_t  tsel_r;
    test_sel_t  tsel_nxt;
    logic [1:0] tdata_r;
    logic [1:0] tdata_nxt;

    always_comb begin
        tsel_nxt  = tsel_r;
        tdata_nxt = tdata_r;
        if (reg_wr && (reg_addr == `CIF_OFS_CTRL)) begin
            tsel_nxt  = reg_wdata[`CIF_TSEL_LSB +: 2];
            tdata_nxt = reg_wdata[`CIF_TDATA_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tsel_r  <= `CIF_RST_TSEL;
            tdata_r <= `CIF_RST_TDATA;
        end else begin
            tsel_r  <= tsel_nxt;
            tdata_r <= tdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin groups: 0..5, bus clock pin (6), bus strobe pin (7), pin 20 (8)

    pin_group_t ctl_r   [`CIF_PIN_N];
    pin_group_t ctl_nxt [`CIF_PIN_N];

    always_comb begin
        for (int i = 0; i < `CIF_PIN_N; i++) begin
            ctl_nxt[i] = ctl_r[i];
        end
        if (reg_wr && (reg_addr == `CIF_OFS_PIN_LO)) begin
            // groups 6 and 7 sit in bits 27:24 and 31:28
            for (int i = 0; i < `CIF_PIN_LO_N; i++) begin
                ctl_nxt[i] = reg_wdata[i*`CIF_GRP_W +: `CIF_GRP_W]; // see (R5) (R11) (R12)
            end
        end
        if (reg_wr && (reg_addr == `CIF_OFS_PIN_HI)) begin
            // only bits 11:8 hold state; the rest is dropped
            ctl_nxt[`CIF_PIN_HI_IDX] = reg_wdata[`CIF_HI_GRP_LSB +: `CIF_GRP_W]; // see (R13) (R15)
        end
        for (int i = 0; i < `CIF_PIN_N; i++) begin
            if (!pin_exists(i)) begin
                ctl_nxt[i] = '0; // see (R14)
            end
        end
        // forced in the next value so the pin never drives, not even for one cycle
        if (pd_en_nxt) begin
            ctl_nxt[`CIF_PIN_PDWN][`CIF_GRP_OE] = 1'b0; // see (R9)
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < `CIF_PIN_N; i++) begin
            if (!resetn) begin
                ctl_r[i] <= reset_group(i); // see (R10) (R11)
            end else begin
                ctl_r[i] <= ctl_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    logic [`CIF_PIN_N-1:0] test_src;
    logic [`CIF_PIN_N-1:0] pin_out_r;
    logic [`CIF_PIN_N-1:0] pin_out_nxt;
    logic [`CIF_PIN_N-1:0] pin_oe_r;
    logic [`CIF_PIN_N-1:0] pin_oe_nxt;

    // reserved select drives zero so a stray test setting stays quiet
    always_comb begin
        case (tsel_nxt) // see (R1)
            `CIF_TSEL_USB: test_src = usb_test_data;
            `CIF_TSEL_MIU: test_src = miu_test_data;
            `CIF_TSEL_CIF: test_src = {{(`CIF_PIN_N-1)/2{tdata_nxt}}, tdata_nxt[0]};
            default:       test_src = '0;
        endcase
    end

    always_comb begin
        for (int i = 0; i < `CIF_PIN_N; i++) begin
            pin_out_nxt[i] = ctl_nxt[i][`CIF_GRP_SRC] ? test_src[i]
                                                      : ctl_nxt[i][`CIF_GRP_DAT]; // see (R5)
            pin_oe_nxt[i]  = ctl_nxt[i][`CIF_GRP_OE]; // see (R6)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0; // see (R10)
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, one cycle after the strobe

    word_t rdata_r;
    word_t rdata_nxt;
    word_t rd_lo;
    word_t rd_hi;
    word_t rd_stat;
    word_t rd_ctrl;

    always_comb begin
        rd_lo   = '0;
        rd_hi   = '0;
        rd_stat = '0;
        rd_ctrl = '0;
        for (int i = 0; i < `CIF_PIN_LO_N; i++) begin
            rd_lo[i*`CIF_GRP_W +: `CIF_GRP_W] = group_view(ctl_r[i], pin_s2_r[i]);
        end
        rd_hi[`CIF_HI_GRP_LSB +: `CIF_GRP_W] =
            group_view(ctl_r[`CIF_PIN_HI_IDX], pin_s2_r[`CIF_PIN_HI_IDX]); // see (R14)
        rd_stat[`CIF_CMD_LSB +: `CIF_FREE_W] = command_queue_free_count; // see (R2)
        rd_stat[`CIF_SRC_LSB +: `CIF_FREE_W] = source_queue_free_count;  // see (R3)
        rd_stat[`CIF_BUSY_BIT]               = engine_busy;              // see (R4)
        rd_ctrl[`CIF_TSEL_LSB +: 2]          = tsel_r;
        rd_ctrl[`CIF_TDATA_LSB +: 2]         = tdata_r;
        rdata_nxt = '0; // see (R15)
        if (reg_rd) begin
            case (reg_addr)
                `CIF_OFS_CTRL:   rdata_nxt = rd_ctrl;
                `CIF_OFS_STATUS: rdata_nxt = rd_stat;
                `CIF_OFS_PIN_LO: rdata_nxt = rd_lo;
                `CIF_OFS_PIN_HI: rdata_nxt = rd_hi;
                default:         rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata          = rdata_r;
    assign pin_out            = pin_out_r;
    assign pin_oe             = pin_oe_r;
    assign mode_strap         = strap_r;
    assign power_down_enable  = pd_en_r;
    assign power_down_input_n = pd_in_n_r;

endmodule
`default_nettype wire

// [cif_gpio_properties.sv]
// checker for the gpio control words and queue status word
// assumes it is bound to cif_gpio and sees only that module's ports
`include "cif_gpio_params.svh"
`default_nettype none
module cif_gpio_properties
    import cif_gpio_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int QUEUE_DEPTH   = 16
) (
    input wire logic                    core_clk,
    input wire logic                    resetn,
    input wire logic [`CIF_ADDR_W-1:0]  reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    input wire logic [`CIF_FREE_W-1:0]  command_queue_free_count,
    input wire logic [`CIF_FREE_W-1:0]  source_queue_free_count,
    input wire logic                    engine_busy,
    input wire logic [`CIF_PIN_N-1:0]   pin_out,
    input wire logic [`CIF_PIN_N-1:0]   pin_oe,
    input wire logic [`CIF_STRAP_N-1:0] mode_strap,
    input wire logic                    power_down_enable,
    input wire logic                    power_down_input_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // a source-select write leaves the drive value to the test mux, so only oe is tied then
    property grp_p(logic [11:0] a, int p, int b);
        reg_wr && reg_addr == a |=> pin_oe[p] == $past(reg_wdata[b+1])
            && ($past(reg_wdata[b+2]) || pin_out[p] == $past(reg_wdata[b+3]));
    endproperty
    ////////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    status_word_a: assert property (reg_rd && reg_addr == `CIF_OFS_STATUS
        |=> reg_rdata == {15'h0, $past(engine_busy), 3'h0, $past(source_queue_free_count),
        3'h0, $past(command_queue_free_count)}) else $error("status word mismatch");
    unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {`CIF_OFS_CTRL,
        `CIF_OFS_STATUS, `CIF_OFS_PIN_LO, `CIF_OFS_PIN_HI}) |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    oe_reset_a: assert property ($rose(resetn) |-> pin_oe == 9'h0)
        else $error("output enabled after reset");
    strap_hold_a: assert property ($past(resetn, 2) |->
        $stable(mode_strap) && $stable(power_down_enable)) else $error("strap changed");
    pd_no_drive_a: assert property (power_down_enable |-> !pin_oe[`CIF_PIN_PDWN])
        else $error("power-down pin driven");
    pd_idle_a: assert property (!power_down_enable |-> power_down_input_n)
        else $error("power-down input active while disabled");
    grp0_write_a: assert property (grp_p(`CIF_OFS_PIN_LO, 0, 0))
        else $error("pin 0 group not applied");
    clock_pin_a: assert property (grp_p(`CIF_OFS_PIN_LO, 6, 24))
        else $error("bus clock pin group not applied");
    strobe_pin_a: assert property (grp_p(`CIF_OFS_PIN_LO, 7, 28))
        else $error("bus strobe pin group not applied");
    pin20_a: assert property (grp_p(`CIF_OFS_PIN_HI, 8, 8))
        else $error("pin 20 group not applied");
    cover property (reg_rd && reg_addr == `CIF_OFS_STATUS);
    cover property (power_down_enable && !power_down_input_n);
    cover property (reg_wr && reg_addr == `CIF_OFS_PIN_HI);
endmodule
bind cif_gpio cif_gpio_properties #(.LARGE_VARIANT(LARGE_VARIANT), .QUEUE_DEPTH(QUEUE_DEPTH))
    cif_gpio_properties_inst (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .command_queue_free_count, .source_queue_free_count, .engine_busy, .pin_out,
    .pin_oe, .mode_strap, .power_down_enable, .power_down_input_n);
`default_nettype wire

// [board_pins.sv]
// board model of the general pins: a pull network plus whatever the device drives
// assumes pin_oe high means the device drives the pin
`include "cif_gpio_params.svh"
`default_nettype none
module board_pins (
    input  wire logic [`CIF_PIN_N-1:0] pin_out,
    input  wire logic [`CIF_PIN_N-1:0] pin_oe,
    input  wire logic [`CIF_PIN_N-1:0] pull,
    output var  logic [`CIF_PIN_N-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released pin falls to its pull level, so a stale value can never pass
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule
`default_nettype wire

// [cif_gpio_tb_top.sv]
// testbench for the gpio control words and queue status word
// assumes the board model on the pins and the bound checker
`include "cif_gpio_params.svh"
`default_nettype none
module cif_gpio_tb_top import cif_gpio_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                   engine_busy = 1'b0, rd_q = 1'b0, b, power_down_enable;
    logic                   power_down_input_n;
    logic [11:0]            reg_addr = 12'h000;
    word_t                  reg_wdata = 32'h0, reg_rdata, w;
    logic [4:0]             command_queue_free_count = 5'h00, source_queue_free_count = 5'h00;
    logic [4:0]             c, s;
    logic [8:0]             usb_test_data = 9'h000, miu_test_data = 9'h000, pull = 9'h0A5;
    logic [8:0]             pin_in, pin_out, pin_oe, exp_pins;
    logic [2:0]             mode_strap;
    word_t                  exp_q[$];
    int                     err_count = 0, num_checks = 0, cyc = 0;

    cif_gpio cif_gpio_inst (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .command_queue_free_count, .source_queue_free_count, .engine_busy,
        .usb_test_data, .miu_test_data, .pin_in, .pin_out, .pin_oe, .mode_strap,
        .power_down_enable, .power_down_input_n);
    board_pins board_pins_inst (.pin_out, .pin_oe, .pull, .pin_in);
    always #4 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // data bits of an input-enabled group read back the pin level
    function automatic word_t fold(word_t v, logic [8:0] lvl);
        for (int i = 0; i < 8; i++) if (v[4*i]) v[4*i+3] = lvl[i];
        return v;
    endfunction
    function automatic logic [7:0] dat(word_t v);
        for (int i = 0; i < 8; i++) dat[i] = v[4*i+3];
    endfunction
    task automatic check(word_t seen, word_t exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(logic [11:0] a, word_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, word_t e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // pins must sit still across the reset so the straps see a settled level
    task automatic do_reset(logic [8:0] p);
        pull <= p;
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        rd_q <= reg_rd;
        if (rd_q) check(reg_rdata, exp_q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(10344));
        do_reset(9'h0A5);
        check(32'(mode_strap), 32'h5);
        check(32'(power_down_enable), 32'h0);
        check(32'(pin_oe), 32'h0);
        rd(`CIF_OFS_PIN_LO, fold(32'h00111100, 9'h0A5));
        rd(`CIF_OFS_PIN_HI, 32'h00000100);
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 5'h00 : (i == 1) ? 5'h10 : 5'($urandom % 17);
            s = 5'h10 - c;
            b = 1'($urandom);
            command_queue_free_count <= c;
            source_queue_free_count <= s;
            engine_busy <= b;
            rd(`CIF_OFS_STATUS, {15'h0, b, 3'h0, s, 3'h0, c});
        end
        repeat (3) begin
            w = ($urandom & 32'hAAAAAAAA) | 32'h22222222;
            wr(`CIF_OFS_PIN_LO, w);
            #1 check(32'(pin_oe[7:0]), 32'hFF);
            check(32'(pin_out[7:0]), 32'(dat(w & 32'h77777777 | w & 32'h88888888)));
            rd(`CIF_OFS_PIN_LO, w & 32'hEEEEEEEE);
        end
        w = ($urandom & 32'h88888888) | 32'h22222222;
        wr(`CIF_OFS_PIN_LO, w);
        rd(12'h010, 32'h0);
        wr(12'h010, $urandom);
        rd(`CIF_OFS_PIN_LO, w);
        w = ($urandom & 32'h88888888) | 32'h11111111;
        wr(`CIF_OFS_PIN_LO, w);
        repeat (3) @(posedge core_clk);
        rd(`CIF_OFS_PIN_LO, fold(w, 9'h0A5));
        usb_test_data <= 9'($urandom);
        miu_test_data <= 9'($urandom);
        for (int k = 0; k < 4; k++) begin
            w = ($urandom & 32'hFFFFFFCF) | 32'(k << 4);
            wr(`CIF_OFS_CTRL, w);
            wr(`CIF_OFS_PIN_LO, 32'h66666666);
            wr(`CIF_OFS_PIN_HI, 32'h00000600);
            // cpu test word: four copies of the two data bits, pin 0 the low bit
            case (k)
                0: exp_pins = usb_test_data;
                1: exp_pins = miu_test_data;
                2: exp_pins = {{4{w[7:6]}}, w[6]};
                default: exp_pins = 9'h000;
            endcase
            #1 check(32'(pin_out), 32'(exp_pins));
            rd(`CIF_OFS_CTRL, w & 32'h000000F0);
        end
        rd(`CIF_OFS_PIN_HI, 32'h00000600);
        // pin 20 pulled high here so its input read-back is really exercised
        do_reset(9'h108);
        check(32'(power_down_enable), 32'h1);
        check(32'(mode_strap), 32'h0);
        check(32'(power_down_input_n), 32'h0);
        rd(`CIF_OFS_PIN_HI, 32'h00000900);
        wr(`CIF_OFS_PIN_LO, 32'h000A0000);
        #1 check(32'(pin_oe), 32'h0);
        repeat (3) @(posedge core_clk);
        end_sim();
    end
endmodule
`default_nettype wire
